// file: hw/pdwd_pkg.sv
// package: register map, codes and timing constants for the process data watchdog block
package pdwd_pkg;

  // register word addresses (modbus register numbers)
  localparam logic [15:0] ADDR_CONN_TIMEOUT   = 16'h0500;
  localparam logic [15:0] ADDR_WD_TIMEOUT     = 16'h07D0;
  localparam logic [15:0] ADDR_FAULT_RESP     = 16'h07D2;
  localparam logic [15:0] ADDR_FAIL_REASON    = 16'h07D4;
  localparam logic [15:0] ADDR_COMMAND        = 16'h07D6;
  localparam logic [15:0] ADDR_DEV_STATUS     = 16'h1F3C;
  localparam logic [15:0] ADDR_DIAG_STATUS    = 16'h1F3D;
  localparam logic [15:0] ADDR_DIAG_PARAM     = 16'h1F3E;
  localparam logic [15:0] ADDR_INPUT_IMAGE    = 16'h1F40;
  localparam logic [15:0] ADDR_OUTPUT_IMAGE   = 16'h2328;

  // function codes
  localparam logic [7:0] FC_READ_COILS    = 8'h01;
  localparam logic [7:0] FC_READ_DISCRETE = 8'h02;
  localparam logic [7:0] FC_READ_HOLDING  = 8'h03;
  localparam logic [7:0] FC_READ_INPUT    = 8'h04;
  localparam logic [7:0] FC_WRITE_COIL    = 8'h05;
  localparam logic [7:0] FC_WRITE_SINGLE  = 8'h06;
  localparam logic [7:0] FC_WRITE_COILS   = 8'h0F;
  localparam logic [7:0] FC_WRITE_MULTI   = 8'h10;
  localparam logic [7:0] FC_READ_WRITE    = 8'h17;

  // exception codes
  localparam logic [7:0] EXC_NONE          = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR  = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

  // substitute behaviour codes
  localparam logic [15:0] RESP_ALL_LOW  = 16'h0000;
  localparam logic [15:0] RESP_ALL_HIGH = 16'h0001;
  localparam logic [15:0] RESP_HOLD     = 16'h0002;

  // command word codes
  localparam logic [15:0] CMD_SET_FAIL = 16'h0010;
  localparam logic [15:0] CMD_ACK_FAIL = 16'h0020;

  // failure reason codes
  localparam logic [15:0] REASON_NONE     = 16'h0000;
  localparam logic [15:0] REASON_USER     = 16'h0009;
  localparam logic [15:0] REASON_WATCHDOG = 16'h000C;
  localparam logic [15:0] REASON_CONN     = 16'h000D;

  // status bit positions
  localparam int STAT_ERROR_BIT = 0;
  localparam int STAT_FAIL_BIT  = 1;

  // timeout limits and reset values
  localparam logic [15:0] TIMEOUT_MIN_MS   = 16'h00C8;
  localparam logic [15:0] TIMEOUT_MAX_MS   = 16'hFDE8;
  localparam logic [15:0] WD_TIMEOUT_RESET = 16'h0000;
  localparam logic [15:0] CONN_TIMEOUT_RST = 16'h0000;

  // timing: 1 ms tick from the 40 MHz system clock
  localparam int CLK_HZ      = 40000000;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;

  // number of client connections
  localparam int NUM_CONN = 8;

  // register request from the protocol engine
  typedef struct packed {
    logic        valid;
    logic [2:0]  conn;
    logic [7:0]  func;
    logic [15:0] addr;
    logic        wr;
    logic [15:0] wdata;
  } reg_req_type;

  // register response to the protocol engine
  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
    logic [7:0]  exc;
  } reg_rsp_type;

endpackage : pdwd_pkg

// file: hw/pdwd_core.sv
// process data watchdog, connection monitoring and modbus register map
//
// Functional notes
// - reset: watchdog disabled, timeout zero
// - any expiry blocks outputs, applies substitutes
// - failure still accepts writes; release uses latest
// - first output write starts, writes restart
// - reads never restart the countdown
// - expiry forces substitutes, sets status bit1
// - failure drives network indicator steady red
// - user halts active watchdog only by zero timeout
// - substitutes held until failure is acknowledged
// - acknowledgement restarts the watchdog countdown
// - watchdog timeout 16-bit register, five functions
// - auto mode: next output write acknowledges
// - manual mode: command register acknowledges
// - eight connections with own monitoring
// - function codes 1-6,15,16,23 mapped to images
// - special registers via 3,4,6,16,23
// - status and diagnostics read-only via 3,4,23
// - write to read-only gives exception 02
// - connection timeout 200..65000, zero disables
// - new timeout applies after function on connection
// - substitute codes: low, high, hold last
// - command 0010 forces, 0020 acknowledges failure in manual mode
// - reason 000C watchdog, 000D connection timeout
`timescale 1ns/1ps

module pdwd_core
  import pdwd_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES  // cycles per millisecond tick
) (
  input  wire logic        clk_sys_i,     // 40 MHz system clock
  input  wire logic        sys_rst_i,     // async reset, active high
  input  wire reg_req_type req_i,         // register request, one cycle pulse
  input  wire logic        manual_ack_i,  // acknowledge mode: 1 manual, 0 auto
  input  wire logic [15:0] inputs_i,      // input process image
  input  wire logic [15:0] diag_status_i, // diagnostic status word
  input  wire logic [15:0] diag_param_i,  // diagnostic parameter word
  output reg_rsp_type      rsp_o,         // register response
  output logic      [15:0] outputs_o,     // physical output drive
  output logic             net_red_o,     // network indicator red
  output logic             net_fail_o     // network failure flag
);

  //////////////////////////////////////////////////////////////////////////////
  // decode

  logic [15:0] wd_timeout_reg;        // watchdog timeout in ms
  logic [15:0] conn_timeout_reg;      // connection timeout in ms
  logic [15:0] fault_resp_reg;        // substitute behaviour code
  logic [15:0] reason_reg;            // failure cause
  logic [15:0] out_image_reg;         // latest written output data
  logic [15:0] last_out_reg;          // outputs before failure, for hold mode
  logic        fail_reg;              // network failure latched
  logic [15:0] wd_cnt_reg;            // watchdog countdown
  logic        wd_run_reg;            // watchdog started
  logic [31:0] tick_cnt_reg;          // ms prescaler
  logic        tick_reg;              // one cycle per ms
  logic [15:0] conn_cnt_reg [NUM_CONN];  // per connection countdown
  logic [15:0] conn_tmo_reg [NUM_CONN];  // per connection applied timeout
  logic        conn_exp;              // some connection expired

  logic is_read_fc, is_write_fc, is_special_fc, is_ro_fc;
  logic is_out, is_in, is_special, is_ro, is_cmd, is_timeout_reg, known;
  logic wr_ok, out_wr, bad_value;
  logic [7:0]  exc;
  logic [15:0] rdata;

  // function code classes
  always_comb begin
    is_read_fc    = req_i.func inside {FC_READ_COILS, FC_READ_DISCRETE, FC_READ_HOLDING, FC_READ_INPUT, FC_READ_WRITE};
    is_write_fc   = req_i.func inside {FC_WRITE_COIL, FC_WRITE_SINGLE, FC_WRITE_COILS, FC_WRITE_MULTI, FC_READ_WRITE};
    is_special_fc = req_i.func inside {FC_READ_HOLDING, FC_READ_INPUT, FC_WRITE_SINGLE, FC_WRITE_MULTI, FC_READ_WRITE};
    is_ro_fc      = req_i.func inside {FC_READ_HOLDING, FC_READ_INPUT, FC_READ_WRITE};
  end

  // address classes and exception selection
  always_comb begin
    is_out         = (req_i.addr == ADDR_OUTPUT_IMAGE);
    is_in          = (req_i.addr == ADDR_INPUT_IMAGE);
    is_timeout_reg = (req_i.addr == ADDR_WD_TIMEOUT) || (req_i.addr == ADDR_CONN_TIMEOUT);
    is_special     = is_timeout_reg || (req_i.addr == ADDR_FAULT_RESP);
    is_cmd         = (req_i.addr == ADDR_COMMAND);
    is_ro          = (req_i.addr == ADDR_FAIL_REASON) || (req_i.addr == ADDR_DEV_STATUS) ||
                     (req_i.addr == ADDR_DIAG_STATUS) || (req_i.addr == ADDR_DIAG_PARAM) || is_in;
    known          = is_out || is_special || is_cmd || is_ro;
    bad_value      = req_i.wr && is_timeout_reg && (req_i.wdata != 16'h0000) &&
                     ((req_i.wdata < TIMEOUT_MIN_MS) || (req_i.wdata > TIMEOUT_MAX_MS));
    exc = EXC_NONE;
    if (!(is_read_fc || is_write_fc)) begin
      exc = EXC_ILLEGAL_FUNC;
    end else if (!known) begin
      exc = EXC_ILLEGAL_ADDR;
    end else if (req_i.wr && !is_write_fc) begin
      exc = EXC_ILLEGAL_FUNC;
    end else if (req_i.wr && is_ro) begin
      exc = EXC_ILLEGAL_ADDR;
    end else if (!req_i.wr && is_cmd) begin
      exc = EXC_ILLEGAL_ADDR;
    end else if ((is_special || is_cmd) && !is_special_fc) begin
      exc = EXC_ILLEGAL_FUNC;
    end else if (is_ro && !is_in && !is_ro_fc) begin
      exc = EXC_ILLEGAL_FUNC;
    end else if (is_in && !is_read_fc) begin
      exc = EXC_ILLEGAL_FUNC;
    end else if (bad_value) begin
      exc = EXC_ILLEGAL_VALUE;
    end
    wr_ok  = req_i.valid && req_i.wr && (exc == EXC_NONE);
    out_wr = wr_ok && is_out;
  end

  // read data mux; bit reads see the same word
  always_comb begin
    case (req_i.addr)
      ADDR_CONN_TIMEOUT: rdata = conn_timeout_reg;
      ADDR_WD_TIMEOUT:   rdata = wd_timeout_reg;
      ADDR_FAULT_RESP:   rdata = fault_resp_reg;
      ADDR_FAIL_REASON:  rdata = reason_reg;
      ADDR_DEV_STATUS:   rdata = {14'h0000, fail_reg, fail_reg | (diag_status_i != 16'h0000)};
      ADDR_DIAG_STATUS:  rdata = diag_status_i;
      ADDR_DIAG_PARAM:   rdata = diag_param_i;
      ADDR_INPUT_IMAGE:  rdata = inputs_i;
      ADDR_OUTPUT_IMAGE: rdata = out_image_reg;
      default:           rdata = 16'h0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // response register

  // answer one cycle after the request
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid <= req_i.valid;
      rsp_o.exc   <= req_i.valid ? exc : EXC_NONE;
      rsp_o.rdata <= (req_i.valid && exc == EXC_NONE && !req_i.wr) ? rdata : 16'h0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers

  // timeouts and substitute code; rejected writes keep old value
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wd_timeout_reg   <= WD_TIMEOUT_RESET;
      conn_timeout_reg <= CONN_TIMEOUT_RST;
      fault_resp_reg   <= RESP_ALL_LOW;
    end else if (wr_ok) begin
      if (req_i.addr == ADDR_WD_TIMEOUT) wd_timeout_reg <= req_i.wdata;
      if (req_i.addr == ADDR_CONN_TIMEOUT) conn_timeout_reg <= req_i.wdata;
      if (req_i.addr == ADDR_FAULT_RESP) fault_resp_reg <= req_i.wdata;
    end
  end

  // output image keeps updating even during failure
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_image_reg <= 16'h0000;
    end else if (out_wr) begin
      out_image_reg <= req_i.func == FC_WRITE_COIL ? (req_i.wdata != 16'h0000 ? 16'h0001 : 16'h0000) : req_i.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // millisecond tick

  // prescaler; a single tick may drift up to one ms against a write
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 32'(TICK_LEN - 1)) begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      tick_reg     <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // watchdog

  logic ack_cmd, set_cmd, wd_exp, ack_ev;

  // acknowledge and force events
  always_comb begin
    set_cmd = wr_ok && is_cmd && (req_i.wdata == CMD_SET_FAIL);
    ack_cmd = wr_ok && is_cmd && (req_i.wdata == CMD_ACK_FAIL);
    ack_ev  = fail_reg && (manual_ack_i ? ack_cmd : out_wr);
    wd_exp  = wd_run_reg && tick_reg && (wd_cnt_reg == 16'h0001);
  end

  // countdown; writing a zero timeout is the only user path that stops it once running
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wd_run_reg <= 1'b0;
      wd_cnt_reg <= 16'h0000;
    end else if (wd_timeout_reg == 16'h0000) begin
      wd_run_reg <= 1'b0;
      wd_cnt_reg <= 16'h0000;
    end else if (ack_ev) begin
      wd_run_reg <= 1'b1;
      wd_cnt_reg <= wd_timeout_reg;
    end else if (out_wr && !fail_reg) begin
      wd_run_reg <= 1'b1;
      wd_cnt_reg <= wd_timeout_reg;
    end else if (wd_exp) begin
      wd_run_reg <= 1'b0;
      wd_cnt_reg <= 16'h0000;
    end else if (wd_run_reg && tick_reg) begin
      wd_cnt_reg <= wd_cnt_reg - 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // connection monitoring

  // each connection adopts the new timeout on its next function
  for (genvar c = 0; c < NUM_CONN; c++) begin : g_conn
    logic hit;
    assign hit = req_i.valid && (req_i.conn == 3'(c));
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        conn_tmo_reg[c] <= CONN_TIMEOUT_RST;
        conn_cnt_reg[c] <= 16'h0000;
      end else if (hit) begin
        conn_tmo_reg[c] <= conn_timeout_reg;
        conn_cnt_reg[c] <= conn_timeout_reg;
      end else if (tick_reg && conn_cnt_reg[c] != 16'h0000 && conn_tmo_reg[c] != 16'h0000) begin
        conn_cnt_reg[c] <= conn_cnt_reg[c] - 16'h0001;
      end
    end
  end

  // expiry when any armed connection counts down to one on a tick
  always_comb begin
    conn_exp = 1'b0;
    for (int c = 0; c < NUM_CONN; c++) begin
      if (tick_reg && conn_tmo_reg[c] != 16'h0000 && conn_cnt_reg[c] == 16'h0001) conn_exp = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // failure state

  // set wins over acknowledge in the same cycle
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fail_reg   <= 1'b0;
      reason_reg <= REASON_NONE;
    end else if (wd_exp) begin
      fail_reg   <= 1'b1;
      reason_reg <= REASON_WATCHDOG;
    end else if (conn_exp) begin
      fail_reg   <= 1'b1;
      reason_reg <= REASON_CONN;
    end else if (set_cmd) begin
      fail_reg   <= 1'b1;
      reason_reg <= REASON_USER;
    end else if (ack_ev) begin
      fail_reg <= 1'b0;
    end
  end

  // output drive: substitutes during failure, image otherwise
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      outputs_o    <= 16'h0000;
      last_out_reg <= 16'h0000;
      net_red_o    <= 1'b0;
      net_fail_o   <= 1'b0;
    end else begin
      net_red_o  <= fail_reg;
      net_fail_o <= fail_reg;
      if (fail_reg) begin
        case (fault_resp_reg)
          RESP_ALL_HIGH: outputs_o <= 16'hFFFF;
          RESP_HOLD:     outputs_o <= last_out_reg;
          default:       outputs_o <= 16'h0000;
        endcase
      end else begin
        outputs_o    <= out_image_reg;
        last_out_reg <= out_image_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_expire;
    wd_exp;
  endsequence

  property p_expiry_sets_fail;
    @(posedge clk_sys_i) disable iff (sys_rst_i) s_expire |=> fail_reg ##1 net_fail_o;
  endproperty
  a_expiry_sets_fail: assert property (p_expiry_sets_fail) else $error("expiry did not set failure");

  property p_low_subst;
    @(posedge clk_sys_i) disable iff (sys_rst_i) fail_reg && fault_resp_reg == RESP_ALL_LOW |=> outputs_o == 16'h0000;
  endproperty
  a_low_subst: assert property (p_low_subst) else $error("substitute low not applied");

  property p_red;
    @(posedge clk_sys_i) disable iff (sys_rst_i) $rose(fail_reg) |=> net_red_o;
  endproperty
  a_red: assert property (p_red) else $error("indicator not red on failure");

  property p_read_no_retrigger;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      wd_run_reg && wd_timeout_reg != 16'h0000 && req_i.valid && !req_i.wr && !tick_reg && !ack_ev |=>
        $stable(wd_cnt_reg);
  endproperty
  a_read_no_retrigger: assert property (p_read_no_retrigger) else $error("read restarted watchdog");

  property p_write_restart;
    // a write during a manual-mode failure only updates the image, it does not retrigger
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      out_wr && (!fail_reg || !manual_ack_i) && wd_timeout_reg != 16'h0000 |=> wd_cnt_reg == $past(wd_timeout_reg);
  endproperty
  a_write_restart: assert property (p_write_restart) else $error("write did not restart watchdog");

  property p_ro_exc;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      req_i.valid && req_i.wr && is_write_fc && is_ro |=> rsp_o.valid && rsp_o.exc == EXC_ILLEGAL_ADDR;
  endproperty
  a_ro_exc: assert property (p_ro_exc) else $error("read-only write not refused");

  property p_short_rejected;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      req_i.valid && req_i.wr && req_i.addr == ADDR_WD_TIMEOUT && bad_value |=> $stable(wd_timeout_reg);
  endproperty
  a_short_rejected: assert property (p_short_rejected) else $error("illegal timeout accepted");

  property p_hold_fail;
    @(posedge clk_sys_i) disable iff (sys_rst_i) fail_reg && !ack_ev |=> fail_reg;
  endproperty
  a_hold_fail: assert property (p_hold_fail) else $error("failure cleared without ack");

  property p_reason_wd;
    @(posedge clk_sys_i) disable iff (sys_rst_i) s_expire |=> reason_reg == REASON_WATCHDOG;
  endproperty
  a_reason_wd: assert property (p_reason_wd) else $error("wrong failure reason");

endmodule : pdwd_core

// file: testbench/modbus_client_model.sv
// client model: issues one register request per call toward the block
`timescale 1ns/1ps

module modbus_client_model
  import pdwd_pkg::*;
(
  input  wire logic   clk_sys_i, // system clock
  output reg_req_type req_o      // request toward the block
);
  // idle until the first call
  initial req_o = '0;

  // request held for one edge, then released with scrambled fields
  // client writes legal and illegal timeouts, commands and retriggers
  task automatic send(input logic [2:0] c, input logic [7:0] f, input logic [15:0] a,
                      input logic w, input logic [15:0] d);
    @(posedge clk_sys_i);
    req_o <= '{valid: 1'b1, conn: c, func: f, addr: a, wr: w, wdata: d};
    @(posedge clk_sys_i);
    // released fields must not look like a repeat of the request
    req_o <= '{valid: 1'b0, conn: ~c, func: ~f, addr: ~a, wr: ~w, wdata: ~d};
  endtask : send
endmodule : modbus_client_model

// file: testbench/testbench.sv
// testbench: register map, watchdog, substitutes and acknowledge modes
`timescale 1ns/1ps

module testbench
  import pdwd_pkg::*;
;
  localparam int TL = 4; // short tick keeps ms counts cheap
  logic        clk_sys_i = 1'b0; // 40 MHz clock
  logic        sys_rst_i = 1'b1; // reset, active high
  reg_req_type req;              // request from client model
  reg_rsp_type rsp;              // response from block
  reg_rsp_type e;                // oldest expected response
  reg_rsp_type exp_q [$];        // expected responses in order
  logic        manual = 1'b0;    // acknowledge mode pin
  logic [15:0] inputs = '0;      // input image level
  logic [15:0] diag_s = '0;      // diagnostic status level
  logic [15:0] diag_p = '0;      // diagnostic parameter level
  logic [15:0] outs;             // output drive
  logic        red;              // network indicator red
  logic        nfail;            // network failure flag
  logic [15:0] d;                // output data in flight
  logic [15:0] h;                // output level held through a failure
  logic [2:0]  cn = 3'h0;        // connection used by requests
  int          seed = 32'h62E39AC9;
  int          fail_count = 0;
  int          checked = 0;
  logic [15:0] codes [3] = '{RESP_ALL_HIGH, RESP_ALL_LOW, RESP_HOLD};
  logic [15:0] ro [6] = '{ADDR_FAIL_REASON, ADDR_DEV_STATUS, ADDR_DIAG_STATUS, ADDR_DIAG_PARAM,
                          ADDR_INPUT_IMAGE, 16'h1234};
  logic [7:0]  rfc [5] = '{FC_READ_COILS, FC_READ_DISCRETE, FC_READ_HOLDING, FC_READ_INPUT, FC_READ_WRITE};

  // clock inverts every half period
  always #12.5 clk_sys_i = ~clk_sys_i;

  modbus_client_model client (.clk_sys_i(clk_sys_i), .req_o(req));

  pdwd_core #(.TICK_LEN(TL)) uut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_i(req), .manual_ack_i(manual),
    .inputs_i(inputs), .diag_status_i(diag_s), .diag_param_i(diag_p), .rsp_o(rsp),
    .outputs_o(outs), .net_red_o(red), .net_fail_o(nfail)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // comparisons and verdict
  task automatic cmp(input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("Error at %0t: expected %h got %h", $time, x, g);
    end
  endtask : cmp

  // levels: outputs, red indicator and flag move together
  task automatic lvl(input logic [15:0] o, input logic f);
    @(negedge clk_sys_i);
    cmp({14'h0, o, f, f}, {14'h0, outs, red, nfail});
  endtask : lvl

  task automatic print_verdict();
    if (exp_q.size() != 0) fail_count++;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // monitor: each response is matched with the oldest note
  always @(negedge clk_sys_i) begin
    if (rsp.valid === 1'b1) begin
      if (exp_q.size() == 0) cmp(32'hDEAD, 32'h0);
      else begin
        e = exp_q.pop_front();
        cmp({8'h0, e.rdata, e.exc}, {8'h0, rsp.rdata, rsp.exc});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stimulus helpers
  task automatic op(input logic [7:0] f, input logic [15:0] a, input logic w, input logic [15:0] wd,
                    input logic [15:0] er, input logic [7:0] ex);
    exp_q.push_back('{valid: 1'b1, rdata: er, exc: ex});
    client.send(cn, f, a, w, wd);
  endtask : op

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : idle

  // bounded wait on the failure flag; a hang ends the run
  task automatic wait_fail(input logic v, input int n);
    for (int i = 0; i < n && nfail !== v; i++) @(negedge clk_sys_i);
    if (nfail !== v) begin
      cmp({31'h0, v}, {31'h0, nfail});
      print_verdict();
    end
  endtask : wait_fail

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    idle(10);
    sys_rst_i <= 1'b0;
    inputs <= 16'($random(seed));
    diag_s <= 16'($random(seed));
    diag_p <= 16'($random(seed));
    cn <= 3'($random(seed));
    idle(1);
    op(FC_READ_HOLDING, ADDR_WD_TIMEOUT, 1'b0, 16'h0, WD_TIMEOUT_RESET, EXC_NONE);
    op(FC_READ_INPUT, ADDR_INPUT_IMAGE, 1'b0, 16'h0, inputs, EXC_NONE);
    op(FC_READ_WRITE, ADDR_DIAG_STATUS, 1'b0, 16'h0, diag_s, EXC_NONE);
    op(FC_READ_HOLDING, ADDR_DIAG_PARAM, 1'b0, 16'h0, diag_p, EXC_NONE);
    op(FC_READ_INPUT, ADDR_DEV_STATUS, 1'b0, 16'h0, {15'h0, |diag_s}, EXC_NONE);
    lvl(16'h0, 1'b0);
    foreach (ro[i]) op(FC_WRITE_SINGLE, ro[i], 1'b1, 16'($random(seed)), 16'h0, EXC_ILLEGAL_ADDR);
    op(FC_WRITE_SINGLE, ADDR_WD_TIMEOUT, 1'b1, 16'h00C7, 16'h0, EXC_ILLEGAL_VALUE);
    op(FC_WRITE_MULTI, ADDR_CONN_TIMEOUT, 1'b1, 16'h0001, 16'h0, EXC_ILLEGAL_VALUE);
    op(FC_READ_HOLDING, ADDR_WD_TIMEOUT, 1'b0, 16'h0, 16'h0, EXC_NONE);
    op(FC_READ_COILS, ADDR_WD_TIMEOUT, 1'b0, 16'h0, 16'h0, EXC_ILLEGAL_FUNC);
    $display("test register map done");
    // every function code except 16 on the output image
    op(FC_WRITE_SINGLE, ADDR_OUTPUT_IMAGE, 1'b1, 16'h0, 16'h0, EXC_NONE);
    op(FC_WRITE_COIL, ADDR_OUTPUT_IMAGE, 1'b1, 16'h0001, 16'h0, EXC_NONE);
    op(FC_WRITE_COILS, ADDR_OUTPUT_IMAGE, 1'b1, 16'h0001, 16'h0, EXC_NONE);
    foreach (rfc[i]) op(rfc[i], ADDR_OUTPUT_IMAGE, 1'b0, 16'h0, 16'h0001, EXC_NONE);
    lvl(16'h0001, 1'b0);
    // timeout set, nothing runs before an output write
    op(FC_WRITE_MULTI, ADDR_WD_TIMEOUT, 1'b1, TIMEOUT_MIN_MS, 16'h0, EXC_NONE);
    op(FC_READ_WRITE, ADDR_WD_TIMEOUT, 1'b0, 16'h0, TIMEOUT_MIN_MS, EXC_NONE);
    idle(900);
    lvl(16'h0001, 1'b0);
    $display("test function codes done");
    foreach (codes[k]) begin
      op(FC_WRITE_SINGLE, ADDR_FAULT_RESP, 1'b1, codes[k], 16'h0, EXC_NONE);
      d = 16'($random(seed));
      op(FC_WRITE_MULTI, ADDR_OUTPUT_IMAGE, 1'b1, d, 16'h0, EXC_NONE);
      wait_fail(1'b0, 5);
      idle(1);
      lvl(d, 1'b0);
      repeat (3) begin
        idle(200);
        op(FC_READ_INPUT, ADDR_OUTPUT_IMAGE, 1'b0, 16'h0, d, EXC_NONE);
      end
      idle(150);
      lvl(d, 1'b0);
      wait_fail(1'b1, 60);
      lvl(k == 0 ? 16'hFFFF : (k == 1 ? 16'h0000 : d), 1'b1);
      op(FC_READ_WRITE, ADDR_DEV_STATUS, 1'b0, 16'h0, 16'h0003, EXC_NONE);
      op(FC_READ_HOLDING, ADDR_FAIL_REASON, 1'b0, 16'h0, REASON_WATCHDOG, EXC_NONE);
    end
    $display("test watchdog done");
    // manual acknowledge through the command word
    op(FC_WRITE_SINGLE, ADDR_WD_TIMEOUT, 1'b1, 16'h0, 16'h0, EXC_NONE);
    op(FC_WRITE_SINGLE, ADDR_OUTPUT_IMAGE, 1'b1, d, 16'h0, EXC_NONE);
    wait_fail(1'b0, 5);
    idle(1);
    manual <= 1'b1;
    op(FC_WRITE_MULTI, ADDR_COMMAND, 1'b1, CMD_SET_FAIL, 16'h0, EXC_NONE);
    wait_fail(1'b1, 5);
    lvl(d, 1'b1);
    op(FC_READ_HOLDING, ADDR_FAIL_REASON, 1'b0, 16'h0, REASON_USER, EXC_NONE);
    op(FC_READ_HOLDING, ADDR_COMMAND, 1'b0, 16'h0, 16'h0, EXC_ILLEGAL_ADDR);
    h = d;
    d = 16'($random(seed));
    op(FC_WRITE_SINGLE, ADDR_OUTPUT_IMAGE, 1'b1, d, 16'h0, EXC_NONE);
    idle(3);
    lvl(h, 1'b1);
    op(FC_READ_WRITE, ADDR_COMMAND, 1'b1, CMD_ACK_FAIL, 16'h0, EXC_NONE);
    wait_fail(1'b0, 5);
    lvl(d, 1'b0);
    idle(900);
    lvl(d, 1'b0);
    $display("test manual acknowledge done");
    // connection monitoring after a function on the connection
    idle(1);
    manual <= 1'b0;
    op(FC_WRITE_SINGLE, ADDR_CONN_TIMEOUT, 1'b1, TIMEOUT_MIN_MS, 16'h0, EXC_NONE);
    op(FC_READ_HOLDING, ADDR_CONN_TIMEOUT, 1'b0, 16'h0, TIMEOUT_MIN_MS, EXC_NONE);
    wait_fail(1'b1, 900);
    op(FC_READ_HOLDING, ADDR_FAIL_REASON, 1'b0, 16'h0, REASON_CONN, EXC_NONE);
    idle(3);
    $display("test connection monitoring done");
    print_verdict();
  end
endmodule : testbench
